// [pcab_pkg.sv]
// shared constants of the configuration access bridge and its target end
package pcab_pkg;

    // register map, byte addresses on the host i/o space
    localparam logic [31:0] CFG_ADDR_OFS    = 32'h0000_0cf8;
    localparam logic [31:0] CFG_DATA_OFS    = 32'h0000_0cfc;
    localparam logic [31:0] BRIDGE_STAT_OFS = 32'h0000_0cf0;

    // address select register fields
    localparam int CA_ENABLE_BIT = 31;
    localparam int CA_BUS_LSB    = 16;
    localparam int CA_BUS_MSB    = 23;
    localparam int CA_DEV_LSB    = 11;
    localparam int CA_DEV_MSB    = 15;
    localparam int CA_FUNC_LSB   = 8;
    localparam int CA_FUNC_MSB   = 10;
    localparam int CA_REG_LSB    = 2;
    localparam int CA_REG_MSB    = 7;
    localparam int CA_TYPE_LSB   = 0;
    localparam int CA_TYPE_MSB   = 1;
    localparam logic [31:0] CA_WRITE_MASK = 32'h8000_ffff;
    localparam logic [31:0] CA_RESET      = 32'h0000_0000;
    localparam logic [1:0]  CFG_TYPE0     = 2'b00;
    localparam logic [1:0]  CFG_TYPE1     = 2'b01;

    // select line of device n is address line SEL_BASE_LINE + n, up to SEL_TOP_LINE
    localparam int SEL_BASE_LINE = 16;
    localparam int SEL_LOW_LINE  = 11;
    localparam int SEL_TOP_LINE  = 31;

    // bridge status register bits
    localparam int ST_ABORT_BIT = 0;
    localparam int ST_SUBTR_BIT = 1;
    localparam int ST_CFGEN_BIT = 2;

    // bus commands, bit 0 set for a write
    localparam logic [3:0] CMD_IO_RD  = 4'h2;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_CFG_RD = 4'ha;
    localparam logic [3:0] CMD_SPEC   = 4'h1;

    localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
    localparam logic [31:0] BURST_STEP = 32'h0000_0004;

    // bus rate: at most 33 MHz from a 100 MHz clock, period rounded up
    localparam int CLK_MHZ      = 100;
    localparam int BUS_MAX_MHZ  = 33;
    localparam int BUS_DIV      = (CLK_MHZ + BUS_MAX_MHZ - 1) / BUS_MAX_MHZ;
    // bus ticks a positive claim may take before the cycle is given up
    localparam int DEVSEL_TICKS = 3;

    // config space: 256 bytes, first 64 bytes the fixed header
    localparam int CFG_WORDS    = 64;
    localparam int HDR_WORDS    = 16;
    localparam int CFG_ID_WORD  = 0;
    localparam int CFG_CMD_WORD = 1;
    localparam int CFG_IO_BAR   = 4;
    localparam int CFG_MEM_BAR  = 5;
endpackage

// [pcab_link_if.sv]
// link between the bridge end and a target end
interface pcab_link_if;
    logic        bus_tick;
    logic        frame;
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        devsel;
    logic        trdy;
    logic [31:0] rdata;

    modport bridge_mp
    (
        output bus_tick,
        output frame,
        output cmd,
        output addr,
        output wdata,
        input  devsel,
        input  trdy,
        input  rdata
    );

    modport target_mp
    (
        input  bus_tick,
        input  frame,
        input  cmd,
        input  addr,
        input  wdata,
        output devsel,
        output trdy,
        output rdata
    );
endinterface

// [pcab_target.sv]
// target end: config space, positive i/o and memory decode
module pcab_target #(
    parameter int          DEV_NUM  = 13,
    parameter int          FUNC_NUM = 0,
    // arbitrary identification word
    parameter logic [31:0] ID_WORD  = 32'h0001_0001
) (
    input  wire logic          clock_i,
    input  wire logic          rst_i,
    pcab_link_if.target_mp     link,
    output logic [31:0]        cmd_word_o,
    output logic               hit_o
);
    localparam int SEL_LINE = pcab_pkg::SEL_BASE_LINE + DEV_NUM;

    logic [31:0] cfg_mem [pcab_pkg::CFG_WORDS];
    logic [31:0] data_mem [pcab_pkg::CFG_WORDS];
    logic [31:0] cmd_reg;
    logic [31:0] io_bar_reg;
    logic [31:0] mem_bar_reg;
    logic [31:0] phase_addr_reg;
    logic        devsel_reg;
    logic        trdy_reg;
    logic [31:0] rdata_reg;
    logic        hit_reg;

    wire         is_write  = link.cmd[0];
    wire  [3:0]  cmd_kind  = {link.cmd[3:1], 1'b0};
    wire  [5:0]  cfg_idx   = link.addr[pcab_pkg::CA_REG_MSB:pcab_pkg::CA_REG_LSB];
    wire  [2:0]  func_f    = link.addr[pcab_pkg::CA_FUNC_MSB:pcab_pkg::CA_FUNC_LSB];
    // type 0 only, select line and own function
    wire         cfg_hit   = (cmd_kind == pcab_pkg::CMD_CFG_RD) && link.addr[SEL_LINE]
                             && (link.addr[1:0] == pcab_pkg::CFG_TYPE0)
                             && (func_f == 3'(FUNC_NUM));
    // full 32-bit byte decode of a 16 byte window
    wire         io_hit    = (cmd_kind == pcab_pkg::CMD_IO_RD) && cmd_reg[0]
                             && (link.addr[31:4] == io_bar_reg[31:4]);
    // doubleword decode, low two lines give the burst order
    wire         mem_hit   = (cmd_kind == pcab_pkg::CMD_MEM_RD) && cmd_reg[1]
                             && (link.addr[31:8] == mem_bar_reg[31:8]);
    wire         any_hit   = cfg_hit || io_hit || mem_hit;
    wire         linear    = (link.addr[1:0] == 2'b00);
    wire  [5:0]  mem_idx   = phase_addr_reg[7:2];
    wire  [5:0]  io_idx    = {4'h0, link.addr[3:2]};
    wire  [31:0] cfg_rd    = (cfg_idx == 6'(pcab_pkg::CFG_ID_WORD))  ? ID_WORD :
                             (cfg_idx == 6'(pcab_pkg::CFG_CMD_WORD)) ? cmd_reg :
                             (cfg_idx == 6'(pcab_pkg::CFG_IO_BAR))   ? io_bar_reg :
                             (cfg_idx == 6'(pcab_pkg::CFG_MEM_BAR))  ? mem_bar_reg :
                             cfg_mem[cfg_idx];
    wire  [31:0] rd_word   = cfg_hit ? cfg_rd :
                             io_hit  ? data_mem[io_idx] : data_mem[mem_idx];
    wire         start     = link.bus_tick && link.frame && !devsel_reg && any_hit;

    assign link.devsel = devsel_reg;
    assign link.trdy   = trdy_reg;
    assign link.rdata  = rdata_reg;
    assign cmd_word_o  = cmd_reg;
    assign hit_o       = hit_reg;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cmd_reg        <= 32'h0000_0000;
            io_bar_reg     <= 32'h0000_0000;
            mem_bar_reg    <= 32'h0000_0000;
            phase_addr_reg <= 32'h0000_0000;
            devsel_reg     <= 1'b0;
            trdy_reg       <= 1'b0;
            rdata_reg      <= 32'h0000_0000;
            hit_reg        <= 1'b0;
        end
        else
        begin
            hit_reg <= start;
            if (link.bus_tick && !link.frame)
            begin
                devsel_reg <= 1'b0;
                trdy_reg   <= 1'b0;
            end
            else if (start)
            begin
                devsel_reg     <= 1'b1;
                phase_addr_reg <= link.addr;
            end
            else if (link.bus_tick && devsel_reg)
            begin
                trdy_reg  <= 1'b1;
                rdata_reg <= rd_word;
                if (trdy_reg && linear)
                    phase_addr_reg <= phase_addr_reg + pcab_pkg::BURST_STEP;
            end
            if (start && is_write && cfg_hit)
            begin
                if (cfg_idx == 6'(pcab_pkg::CFG_CMD_WORD))
                    cmd_reg <= link.wdata;
                if (cfg_idx == 6'(pcab_pkg::CFG_IO_BAR))
                    io_bar_reg <= link.wdata;
                if (cfg_idx == 6'(pcab_pkg::CFG_MEM_BAR))
                    mem_bar_reg <= link.wdata;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (start && is_write && cfg_hit && cfg_idx >= 6'(pcab_pkg::HDR_WORDS))
            cfg_mem[cfg_idx] <= link.wdata;
    end

    always_ff @(posedge clock_i)
    begin
        if (start && is_write && io_hit)
            data_mem[io_idx][link.addr[1:0]*8 +: 8] <= link.wdata[7:0];
        else if (start && is_write && mem_hit)
            data_mem[link.addr[7:2]] <= link.wdata;
    end
endmodule

// [pcab_bridge.sv]
// bridge end: host registers on avalon, configuration and i/o cycles on the link
//
// The Avalon-MM interface to the registers was chosen for this implementation.
module pcab_bridge (
    input  wire logic          clock_i,
    input  wire logic          rst_i,
    input  wire logic [31:0]   avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    input  wire logic          mem_space_i,
    pcab_link_if.bridge_mp     link
);
    typedef enum logic [1:0]
    {
        S_IDLE = 2'b00,
        S_BUS  = 2'b01,
        S_ACK  = 2'b10
    } pcab_state_t;

    pcab_state_t state_reg;
    logic [31:0] cfg_addr_reg;
    logic [2:0]  stat_reg;
    logic [1:0]  div_reg;
    logic        tick_reg;
    logic        frame_reg;
    logic [3:0]  cmd_reg;
    logic [31:0] addr_reg;
    logic [31:0] wdata_reg;
    logic [31:0] rdata_reg;
    logic        waitreq_reg;
    logic        is_cfg_reg;
    logic [1:0]  wait_cnt_reg;
    logic [31:0] sel_lines;

    wire         req        = avs_read || avs_write;
    wire         hit_addr   = (avs_address == pcab_pkg::CFG_ADDR_OFS);
    wire         hit_stat   = (avs_address == pcab_pkg::BRIDGE_STAT_OFS);
    wire         hit_data   = (avs_address == pcab_pkg::CFG_DATA_OFS);
    wire         cfg_en     = cfg_addr_reg[pcab_pkg::CA_ENABLE_BIT];
    wire  [4:0]  dev_num    = cfg_addr_reg[pcab_pkg::CA_DEV_MSB:pcab_pkg::CA_DEV_LSB];
    wire  [1:0]  cyc_type   = cfg_addr_reg[pcab_pkg::CA_TYPE_MSB:pcab_pkg::CA_TYPE_LSB];
    wire  [10:0] func_reg_f = cfg_addr_reg[pcab_pkg::CA_FUNC_MSB:pcab_pkg::CA_TYPE_LSB];
    wire         go_cfg     = hit_data && cfg_en;
    // type 1 passes the whole address
    wire  [31:0] cfg_bus_a  = (cyc_type == pcab_pkg::CFG_TYPE1) ? cfg_addr_reg
                              : {sel_lines[31:11], func_reg_f[10:2], pcab_pkg::CFG_TYPE0};
    wire  [3:0]  base_cmd   = go_cfg ? pcab_pkg::CMD_CFG_RD :
                              mem_space_i ? pcab_pkg::CMD_MEM_RD : pcab_pkg::CMD_IO_RD;
    wire  [3:0]  next_cmd   = {base_cmd[3:1], avs_write};
    wire  [31:0] next_addr  = go_cfg ? cfg_bus_a : avs_address;
    wire         timed_out  = (wait_cnt_reg == 2'(pcab_pkg::DEVSEL_TICKS - 1));
    wire  [31:0] local_rd   = hit_addr ? cfg_addr_reg
                              : hit_stat ? {29'h0000_0000, stat_reg} : 32'h0000_0000;
    // bus number and reserved bits stay zero
    wire  [31:0] addr_wr    = avs_writedata & pcab_pkg::CA_WRITE_MASK;

    // device n to line 16 plus n for n up to 15, higher device numbers to no line
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++)
        begin : g_sel
            if (gi >= pcab_pkg::SEL_BASE_LINE && gi <= pcab_pkg::SEL_TOP_LINE)
                assign sel_lines[gi] = (dev_num == 5'(gi - pcab_pkg::SEL_BASE_LINE));
            else
                assign sel_lines[gi] = 1'b0;
        end
    endgenerate

    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = waitreq_reg;
    assign link.bus_tick   = tick_reg;
    assign link.frame      = frame_reg;
    assign link.cmd        = cmd_reg;
    assign link.addr       = addr_reg;
    assign link.wdata      = wdata_reg;

    // bus rate from a divider, same clock
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            div_reg  <= 2'b00;
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= (div_reg == 2'(pcab_pkg::BUS_DIV - 1));
            div_reg  <= (div_reg == 2'(pcab_pkg::BUS_DIV - 1)) ? 2'b00 : div_reg + 2'b01;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg    <= S_IDLE;
            cfg_addr_reg <= pcab_pkg::CA_RESET;
            stat_reg     <= 3'b000;
            frame_reg    <= 1'b0;
            cmd_reg      <= 4'h0;
            addr_reg     <= 32'h0000_0000;
            wdata_reg    <= 32'h0000_0000;
            rdata_reg    <= 32'h0000_0000;
            waitreq_reg  <= 1'b1;
            is_cfg_reg   <= 1'b0;
            wait_cnt_reg <= 2'b00;
        end
        else
        begin
            stat_reg[pcab_pkg::ST_CFGEN_BIT] <= cfg_en;
            case (state_reg)
                S_IDLE:
                begin
                    if (req && (hit_addr || hit_stat))
                    begin
                        if (avs_write && hit_addr)
                            cfg_addr_reg <= addr_wr;
                        rdata_reg   <= local_rd;
                        waitreq_reg <= 1'b0;
                        state_reg   <= S_ACK;
                    end
                    else if (req)
                    begin
                        cmd_reg      <= next_cmd;
                        addr_reg     <= next_addr;
                        wdata_reg    <= avs_writedata;
                        is_cfg_reg   <= go_cfg;
                        wait_cnt_reg <= 2'b00;
                        state_reg    <= S_BUS;
                    end
                end
                S_BUS:
                begin
                    if (tick_reg)
                    begin
                        if (!frame_reg)
                            frame_reg <= 1'b1;
                        else if (link.trdy)
                        begin
                            frame_reg   <= 1'b0;
                            rdata_reg   <= link.rdata;
                            stat_reg[1:0] <= 2'b00;
                            waitreq_reg <= 1'b0;
                            state_reg   <= S_ACK;
                        end
                        else if (!link.devsel && timed_out)
                        begin
                            frame_reg   <= 1'b0;
                            rdata_reg   <= pcab_pkg::ALL_ONES;
                            stat_reg[pcab_pkg::ST_ABORT_BIT] <= is_cfg_reg;
                            stat_reg[pcab_pkg::ST_SUBTR_BIT] <= !is_cfg_reg;
                            waitreq_reg <= 1'b0;
                            state_reg   <= S_ACK;
                        end
                        else if (!link.devsel)
                            wait_cnt_reg <= wait_cnt_reg + 2'b01;
                    end
                end
                S_ACK:
                begin
                    waitreq_reg <= 1'b1;
                    state_reg   <= S_IDLE;
                end
                default:
                begin
                    frame_reg   <= 1'b0;
                    waitreq_reg <= 1'b1;
                    state_reg   <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// [pcab_link_props.sv]
// link checker between the bridge end and the target end
module pcab_link_props (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        bus_tick,
    input wire logic        frame,
    input wire logic [3:0]  cmd,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic        devsel,
    input wire logic        trdy,
    input wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dck @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    wire cfg = frame && (cmd[3:1] == 3'h5);
    wire t0  = cfg && (addr[1:0] == 2'h0);

    AST_TICK_RATE: assert property (bus_tick |=> !bus_tick [*3] ##1 bus_tick)
        else $error("bus tick spacing wrong");
    AST_ONE_SEL: assert property (t0 |-> $onehot0(addr[31:11]))
        else $error("several select lines high");
    AST_CLAIM_FRAME: assert property ($rose(devsel) |-> frame)
        else $error("claim outside a frame");
    AST_TRDY_AFTER: assert property ($rose(trdy) |-> devsel && frame)
        else $error("data ready without claim");
    AST_ADDR_HOLD: assert property (frame && $past(frame) |->
        $stable(addr) && $stable(cmd) && $stable(wdata))
        else $error("address phase changed in a cycle");
    AST_FRAME_END: assert property ($rose(frame) |-> ##[1:40] !frame)
        else $error("cycle never ended");
    AST_TYPE1_IDLE: assert property ($rose(devsel) && cfg |-> addr[1:0] == 2'h0)
        else $error("type 1 cycle claimed");
    AST_SEL_LINE: assert property ($rose(devsel) && cfg |-> addr[29])
        else $error("claim without its select line");
    AST_FUNC_MATCH: assert property ($rose(devsel) && cfg |-> addr[10:8] == 3'h0)
        else $error("claim for another function");

    cover property ($rose(devsel) && cfg);
    cover property ($fell(frame) && !devsel);
    cover property ($rose(trdy) && (rdata != 32'h0000_0000));
endmodule

// [pci_config_access_bridge_test.sv]
// testbench: host accesses through bridge and target joined by the link
module pci_config_access_bridge_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] SEL  = pcab_pkg::CFG_ADDR_OFS;
    localparam logic [31:0] WIN  = pcab_pkg::CFG_DATA_OFS;
    localparam logic [31:0] STS  = pcab_pkg::BRIDGE_STAT_OFS;
    localparam logic [31:0] ONES = pcab_pkg::ALL_ONES;
    // arbitrary identification word
    localparam logic [31:0] ID   = 32'h0000_5a5a;
    logic        clock_i         = 1'h0;
    logic        rst_i           = 1'h1;
    logic [31:0] avs_address     = 32'h0000_0000;
    logic        avs_read        = 1'h0;
    logic        avs_write       = 1'h0;
    logic [31:0] avs_writedata   = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        mem_space_i     = 1'h0;
    logic [31:0] cmd_word;
    logic        hit_o;
    logic        hit_seen        = 1'h0;
    logic [31:0] bad [4];
    int          miscompares     = 0;
    int          num_checks      = 0;
    int          cycles          = 0;

    pcab_link_if lk ();
    pcab_bridge pcab_bridge_inst (
        .clock_i         (clock_i),
        .rst_i           (rst_i),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .mem_space_i     (mem_space_i),
        .link            (lk.bridge_mp)
    );
    pcab_target #(.ID_WORD (ID)) pcab_target_inst (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .link       (lk.target_mp),
        .cmd_word_o (cmd_word),
        .hit_o      (hit_o)
    );
    pcab_link_props pcab_link_props_inst (
        .clock_i  (clock_i),
        .rst_i    (rst_i),
        .bus_tick (lk.bus_tick),
        .frame    (lk.frame),
        .cmd      (lk.cmd),
        .addr     (lk.addr),
        .wdata    (lk.wdata),
        .devsel   (lk.devsel),
        .trdy     (lk.trdy),
        .rdata    (lk.rdata)
    );

    always #5 clock_i = ~clock_i;

    always @(posedge clock_i)
    begin
        cycles <= cycles + 1;
        if (hit_o === 1'h1)
            hit_seen <= 1'h1;
        // the whole sequence needs about 450 clocks
        if (cycles == 6000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    function automatic logic [31:0] ca(input logic [4:0] dev, input logic [2:0] fn,
                                       input logic [5:0] idx, input logic [1:0] typ);
        return {1'h1, 15'h0000, dev, fn, idx, typ};
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // request held until waitrequest is seen low
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clock_i);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clock_i); while (avs_waitrequest !== 1'h0);
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'h1, a, d, q);
    endtask

    // mask keeps lanes the target leaves undefined out of the compare
    task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp,
                      input logic [31:0] m);
        logic [31:0] q;
        xfer(1'h0, a, 32'h0000_0000, q);
        check(name, exp & m, q & m);
    endtask

    task automatic cfg_wr(input logic [5:0] idx, input logic [31:0] d);
        wr(SEL, ca(5'h0d, 3'h0, idx, 2'h0));
        wr(WIN, d);
    endtask

    initial
    begin
        bad = '{ca(5'h0c, 3'h0, 6'h10, 2'h0), ca(5'h14, 3'h0, 6'h10, 2'h0),
                ca(5'h0d, 3'h1, 6'h10, 2'h0), ca(5'h0d, 3'h0, 6'h10, 2'h1)};
        repeat (20) @(posedge clock_i);
        rst_i <= 1'h0;
        rd("sel_reset", SEL, 32'h0000_0000, ONES);
        wr(SEL, ONES);
        rd("sel_mask", SEL, 32'h8000_ffff, ONES);
        rd("cfg_enable", STS, 32'h0000_0004, 32'h0000_0004);
        for (int i = 0; i < 2; i++)
            cfg_wr(6'(16 + i), 32'h1234_5678 + 32'(i));
        for (int i = 0; i < 2; i++)
        begin
            wr(SEL, ca(5'h0d, 3'h0, 6'(16 + i), 2'h0));
            rd("cfg_word", WIN, 32'h1234_5678 + 32'(i), ONES);
        end
        // other device, no line, other function, type 1: all abort
        for (int k = 0; k < 4; k++)
        begin
            wr(SEL, bad[k]);
            rd("cfg_abort", WIN, ONES, ONES);
            rd("abort_flag", STS, 32'h0000_0001, 32'h0000_0001);
        end
        wr(SEL, ca(5'h0d, 3'h0, 6'h00, 2'h0));
        rd("id_word", WIN, ID, ONES);
        cfg_wr(6'h01, 32'h0000_0003);
        check("cmd_word", 32'h0000_0003, cmd_word);
        cfg_wr(6'h04, 32'h0000_1000);
        cfg_wr(6'h05, 32'h0010_0000);
        wr(SEL, 32'h0000_0000);
        wr(32'h0000_1002, 32'h0000_005a);
        rd("io_lane", 32'h0000_1000, 32'h005a_0000, 32'h00ff_0000);
        check("hit_seen", 32'h0000_0001, {31'h0000_0000, hit_seen});
        rd("claim_flag", STS, 32'h0000_0000, 32'h0000_0002);
        rd("win_as_io", WIN, ONES, ONES);
        rd("subtr_flag", STS, 32'h0000_0002, 32'h0000_0002);
        mem_space_i <= 1'h1;
        wr(32'h0010_0008, 32'h8765_4321);
        wr(32'h0010_000c, 32'h0bad_f00d);
        rd("mem_w2", 32'h0010_0008, 32'h8765_4321, ONES);
        rd("mem_w3", 32'h0010_000c, 32'h0bad_f00d, ONES);
        rd("mem_miss", 32'h0020_0000, ONES, ONES);
        mem_space_i <= 1'h0;
        print_verdict();
    end
endmodule
